// ---- bench/rsw_ctrl_test.sv ----
`timescale 1ns/1ns
module rsw_ctrl_test;
  logic ref_clk, rst_n, rst_pin_n, low_voltage, lpo_clk, lpo_run, lpo_ph;
  logic opcode_bad, access_bad, clock_lost, sleep_exec, background_instruction;
  logic low_voltage_reset_en, background_mode_en;
  logic [1:0] reg_addr, dbg_addr;
  logic reg_wr, reg_rd, dbg_wr;
  logic [7:0] reg_wdata, reg_rdata, dbg_wdata, v, low_cnt, hold_len;
  logic sys_rst_n, sleep_allow, uart2_pin_sel, i2c_pin_sel;
  int failures, total_checks, cyc, n;

  rsw_ctrl #(.WD_BUS_PER1(64), .WD_BUS_PER2(128), .WD_BUS_PER3(256), .RESET_HOLD(16)) i_dut (
    .ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .dbg_wr, .dbg_addr, .dbg_wdata, .rst_pin_n, .low_voltage, .lpo_clk,
    .opcode_bad, .access_bad, .clock_lost, .low_voltage_reset_en, .sleep_exec,
    .background_instruction, .background_mode_en, .sys_rst_n, .sleep_allow,
    .uart2_pin_sel, .i2c_pin_sel);
  rsw_host i_host (.ref_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .dbg_wr, .dbg_addr, .dbg_wdata);

  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Slow clock stands still unless asked, so default timeouts never fire
  always @(posedge ref_clk) begin
    if (lpo_run) begin
      lpo_ph <= ~lpo_ph;
      if (lpo_ph) begin
        lpo_clk <= ~lpo_clk;
      end
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      $display("timeout at cycle %0d", cyc);
      end_sim();
    end
  end
  // Length of the last system reset, counted edge by edge
  always @(posedge ref_clk) begin
    if (sys_rst_n === 1'h0) begin
      low_cnt <= low_cnt + 8'h01;
    end else begin
      if (low_cnt != 8'h00) begin
        hold_len <= low_cnt;
      end
      low_cnt <= 8'h00;
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_rst(input int lim);
    n = 0;
    while (sys_rst_n === 1'h1 && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  task automatic hold_out();
    int k;
    k = 0;
    while (sys_rst_n === 1'h0 && k < 40) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    @(posedge ref_clk);
    #1;
    check("hold cycles", hold_len, 8'h10);
  endtask
  task automatic no_entry(input string what);
    wait_rst(20);
    check(what, {7'h00, sys_rst_n}, 8'h01);
  endtask
  task automatic entry(input int lim, input logic [7:0] exp);
    wait_rst(lim);
    check("entry", {7'h00, sys_rst_n}, 8'h00);
    hold_out();
    i_host.rd(rsw_pkg::RCS_IDX, v);
    check("status", v, exp);
  endtask
  // Source bits: pin, background, sleep, low voltage, clock, access, opcode
  task automatic t_src(input logic [6:0] s, input logic [1:0] en, input logic [7:0] exp);
    @(posedge ref_clk);
    {rst_pin_n, background_instruction, sleep_exec, low_voltage} <= {~s[6], s[5:3]};
    {clock_lost, access_bad, opcode_bad} <= s[2:0];
    {background_mode_en, low_voltage_reset_en} <= en;
    // Sources stay up until judged; a one-cycle pin pulse is filtered out
    if (exp === 8'hff) begin
      no_entry("no entry");
    end else begin
      wait_rst(10);
      check("entry", {7'h00, sys_rst_n}, 8'h00);
    end
    @(posedge ref_clk);
    {rst_pin_n, background_instruction, sleep_exec, low_voltage} <= 4'h8;
    {clock_lost, access_bad, opcode_bad} <= 3'h0;
    if (exp !== 8'hff) begin
      hold_out();
      i_host.rd(rsw_pkg::RCS_IDX, v);
      check("status", v, exp);
    end
  endtask
  task automatic t_wd(input logic [7:0] opt, input logic [7:0] wdo, input int per,
    input logic slow);
    lpo_run <= slow;
    i_host.setup(opt, wdo);
    wait_rst(per + 40);
    check("period", 8'(n >= per - 8 && n <= per + 8), 8'h01);
    hold_out();
    i_host.rd(rsw_pkg::RCS_IDX, v);
    check("wd flag", v, 8'h20);
    lpo_run <= 1'h0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_por();
    i_host.rd(rsw_pkg::RCS_IDX, v);
    check("por status", v, 8'h82);
    i_host.rd(rsw_pkg::RCS_IDX, v);
    check("status reread", v, 8'h82);
    i_host.rd(rsw_pkg::DFR_IDX, v);
    check("debug reg", v, 8'h00);
    i_host.rd(rsw_pkg::SOO_IDX, v);
    check("options reset", v, 8'hc0);
    i_host.rd(rsw_pkg::WDO_IDX, v);
    check("wd options reset", v, 8'h00);
    $display("test por done");
  endtask
  task automatic t_dbg();
    i_host.wr(rsw_pkg::DFR_IDX, 8'h01);
    no_entry("user force");
    i_host.rd(rsw_pkg::DFR_IDX, v);
    check("debug reads zero", v, 8'h00);
    i_host.force_rst();
    entry(10, 8'h00);
    $display("test debug done");
  endtask
  task automatic t_srcs();
    t_src(7'h01, 2'h0, 8'h10);
    t_src(7'h02, 2'h0, 8'h08);
    t_src(7'h04, 2'h0, 8'h04);
    t_src(7'h08, 2'h1, 8'h02);
    t_src(7'h08, 2'h0, 8'hff);
    t_src(7'h10, 2'h0, 8'h10);
    t_src(7'h20, 2'h0, 8'h10);
    t_src(7'h20, 2'h2, 8'hff);
    t_src(7'h40, 2'h0, 8'h40);
    t_src(7'h03, 2'h0, 8'h18);
    $display("test sources done");
  endtask
  task automatic t_opts();
    i_host.setup(8'h28, 8'h00);
    #1;
    check("pin sels", {5'h00, sleep_allow, uart2_pin_sel, i2c_pin_sel}, 8'h05);
    i_host.wr(rsw_pkg::SOO_IDX, 8'hd8);
    i_host.rd(rsw_pkg::SOO_IDX, v);
    check("options once", v, 8'h28);
    i_host.wr(rsw_pkg::RCS_IDX, 8'h12);
    no_entry("wd off");
    t_src(7'h10, 2'h0, 8'hff);
    i_host.force_rst();
    entry(10, 8'h00);
    i_host.rd(rsw_pkg::SOO_IDX, v);
    check("options reopened", v, 8'hc0);
    $display("test options done");
  endtask
  task automatic t_key();
    i_host.refresh();
    no_entry("refresh");
    i_host.rd(rsw_pkg::RCS_IDX, v);
    check("flags kept", v, 8'h00);
    i_host.wr(rsw_pkg::RCS_IDX, 8'h12);
    entry(10, 8'h20);
    i_host.setup(8'h50, 8'h80);
    check("uart2 sel", {5'h00, sleep_allow, uart2_pin_sel, i2c_pin_sel}, 8'h02);
    repeat (40) @(posedge ref_clk);
    i_host.refresh();
    wait_rst(200);
    check("after refresh", 8'(n >= 56 && n <= 72), 8'h01);
    hold_out();
    $display("test key done");
  endtask
  task automatic t_win();
    i_host.setup(8'h40, 8'hc0);
    repeat (20) @(posedge ref_clk);
    i_host.wr(rsw_pkg::RCS_IDX, rsw_pkg::KEY_ARM);
    entry(6, 8'h20);
    i_host.setup(8'h40, 8'hc0);
    repeat (52) @(posedge ref_clk);
    i_host.refresh();
    no_entry("window refresh");
    $display("test window done");
  endtask
  initial begin
    rst_n = 1'h0;
    {rst_pin_n, low_voltage, lpo_clk, lpo_run, lpo_ph} = 5'h10;
    {opcode_bad, access_bad, clock_lost, sleep_exec, background_instruction} = 5'h00;
    {low_voltage_reset_en, background_mode_en} = 2'h0;
    failures = 0;
    total_checks = 0;
    cyc = 0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_por();
    t_dbg();
    t_srcs();
    t_opts();
    t_key();
    t_wd(8'h40, 8'h80, 64, 1'h0);
    t_wd(8'h80, 8'h80, 128, 1'h0);
    t_wd(8'hc0, 8'h80, 256, 1'h0);
    t_wd(8'h40, 8'h00, 128, 1'h1);
    t_wd(8'h80, 8'h00, 1024, 1'h1);
    t_wd(8'hc0, 8'h00, 4096, 1'h1);
    $display("test watchdog done");
    t_win();
    end_sim();
  end
endmodule

// ---- bench/rsw_host.sv ----
`timescale 1ns/1ns
module rsw_host (
  // Clock and read data
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  // Register port
  output logic [1:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  // Debug host port
  output logic dbg_wr,
  output logic [1:0] dbg_addr,
  output logic [7:0] dbg_wdata
);
  initial begin
    {reg_wr, reg_rd, dbg_wr} = 3'h0;
    {reg_addr, dbg_addr} = 4'h0;
    {reg_wdata, dbg_wdata} = 16'h0000;
  end
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Idle data shows the inverse of the last value, never a stale copy
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic refresh();
    wr(rsw_pkg::RCS_IDX, rsw_pkg::KEY_ARM);
    wr(rsw_pkg::RCS_IDX, rsw_pkg::KEY_FIRE);
  endtask
  task automatic setup(input logic [7:0] opt, input logic [7:0] wdo);
    wr(rsw_pkg::SOO_IDX, opt);
    wr(rsw_pkg::WDO_IDX, wdo);
  endtask
  task automatic force_rst();
    @(posedge ref_clk);
    dbg_addr <= rsw_pkg::DFR_IDX;
    dbg_wdata <= 8'h01;
    dbg_wr <= 1'h1;
    @(posedge ref_clk);
    dbg_wr <= 1'h0;
    dbg_wdata <= 8'hfe;
  endtask
endmodule

// ---- verilog/rsw_ctrl.sv ----
`timescale 1ns/1ns
// What this block does
// - Status flags read-only; reads never change them
// - Debug forced reset leaves all flags clear
// - Bad key write while enabled resets
// - Key 0x55 then 0xAA clears watchdog
// - Power-on sets bits 7 and 1
// - Non-debug entry sets active sources, clears others
// - Bit 6 marks reset pin low
// - Bit 5 marks watchdog timeout
// - Bit 4 marks bad opcode incl. sleep/background
// - Bit 3 marks bad memory access
// - Bit 2 marks external clock loss
// - Bit 1 marks gated low-voltage reset
// - Debug register ignores program writes, reads zero
// - Debug host bit 0 write forces reset
// - Options accept first write only, readable
// - Bit 5 allows sleep, else bad opcode
// - Bits 4 and 3 pick pin positions
// - Timeout field bits 7:6, zero disables
// - Slow clock periods 32, 256, 1024
// - Bus clock periods 2^13, 2^16, 2^18
// - Window mode refresh only last quarter
// - Clock select 0 slow, 1 bus
// - Early write in window mode resets
module rsw_ctrl #(
  parameter int unsigned WD_BUS_PER1 = 8192,
  parameter int unsigned WD_BUS_PER2 = 65536,
  parameter int unsigned WD_BUS_PER3 = 262144,
  parameter int unsigned RESET_HOLD = 16
) (
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Background debug write port
  input wire logic dbg_wr,
  input wire logic [1:0] dbg_addr,
  input wire logic [7:0] dbg_wdata,
  // Asynchronous sources
  input wire logic rst_pin_n,
  input wire logic low_voltage,
  input wire logic lpo_clk,
  // Same-clock sources
  input wire logic opcode_bad,
  input wire logic access_bad,
  input wire logic clock_lost,
  input wire logic low_voltage_reset_en,
  input wire logic sleep_exec,
  input wire logic background_instruction,
  input wire logic background_mode_en,
  // System outputs
  output logic sys_rst_n,
  output logic sleep_allow,
  output logic uart2_pin_sel,
  output logic i2c_pin_sel
);
  localparam int HOLD_W = $clog2(RESET_HOLD + 1);
  localparam logic [2:0] SYNC_RST = 3'b001;

  rsw_wdog_if wd ();

  rsw_pkg::rsw_state_e state_ff;
  rsw_pkg::rsw_state_e nxt_state;
  logic [HOLD_W-1:0] hold_ff;
  logic [7:0] status_ff;
  logic [7:0] soo_ff;
  logic [7:0] wdo_ff;
  logic soo_once_ff;
  logic wdo_once_ff;
  logic arm_ff;
  logic [7:0] rdata_ff;
  logic sys_rst_n_ff;
  logic por_chk_ff;
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [2:0] s3_ff;
  logic [2:0] lvl_ff;
  logic [2:0] lvl_prev_ff;
  logic running;
  logic wd_on;
  logic key_write;
  logic bad_key;
  logic win_bad;
  logic refresh;
  logic pin_src;
  logic wd_src;
  logic opc_src;
  logic lv_src;
  logic dbg_src;
  logic entry;
  logic [7:0] cause;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Bit 0 reset pin, bit 1 supply monitor, bit 2 slow clock.
  // A level counts only once the second and third stages agree.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_ff[gi] <= SYNC_RST[gi];
          s2_ff[gi] <= SYNC_RST[gi];
          s3_ff[gi] <= SYNC_RST[gi];
          lvl_ff[gi] <= SYNC_RST[gi];
          lvl_prev_ff[gi] <= SYNC_RST[gi];
        end else begin
          s1_ff[gi] <= (gi == 0) ? rst_pin_n : ((gi == 1) ? low_voltage : lpo_clk);
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          lvl_prev_ff[gi] <= lvl_ff[gi];
          if (s2_ff[gi] == s3_ff[gi]) begin
            lvl_ff[gi] <= s3_ff[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Watchdog hookup
  // ----------------------------------------
  assign wd.timeout_sel = soo_ff[rsw_pkg::SOO_TO_HI:rsw_pkg::SOO_TO_LO];
  assign wd.clk_sel = wdo_ff[rsw_pkg::WDO_CLK];
  assign wd.window_en = wdo_ff[rsw_pkg::WDO_WIN];
  assign wd.tick = lvl_ff[2] && !lvl_prev_ff[2];
  assign wd.clear = refresh || (state_ff == rsw_pkg::ST_HOLD);

  rsw_wdog_cnt #(
    .BUS_PER1(WD_BUS_PER1),
    .BUS_PER2(WD_BUS_PER2),
    .BUS_PER3(WD_BUS_PER3)
  ) u_cnt (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wd(wd.cnt)
  );

  // ----------------------------------------
  // Reset sources
  // ----------------------------------------
  assign running = (state_ff == rsw_pkg::ST_RUN);
  assign wd_on = (wd.timeout_sel != 2'h0);
  assign key_write = running && reg_wr && (reg_addr == rsw_pkg::RCS_IDX);
  assign bad_key = wd_on && key_write && (reg_wdata != rsw_pkg::KEY_ARM)
    && (reg_wdata != rsw_pkg::KEY_FIRE);
  assign win_bad = wd_on && key_write && wd.early;
  assign refresh = wd_on && key_write && arm_ff && !wd.early
    && (reg_wdata == rsw_pkg::KEY_FIRE);
  assign pin_src = !lvl_ff[0];
  assign wd_src = wd.expire || bad_key || win_bad;
  assign opc_src = opcode_bad || (sleep_exec && !soo_ff[rsw_pkg::SOO_SLEEP])
    || (background_instruction && !background_mode_en);
  assign lv_src = lvl_ff[1] && low_voltage_reset_en;
  assign dbg_src = dbg_wr && (dbg_addr == rsw_pkg::DFR_IDX)
    && dbg_wdata[rsw_pkg::DFR_BIT];
  assign entry = running && (pin_src || wd_src || opc_src || access_bad
    || clock_lost || lv_src || dbg_src);

  always_comb begin
    cause = 8'h00;
    cause[rsw_pkg::B_PIN] = pin_src;
    cause[rsw_pkg::B_WDOG] = wd_src;
    cause[rsw_pkg::B_OPC] = opc_src;
    cause[rsw_pkg::B_ACC] = access_bad;
    cause[rsw_pkg::B_CLK] = clock_lost;
    cause[rsw_pkg::B_LV] = lv_src;
  end

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      rsw_pkg::ST_RUN: begin
        if (entry) begin
          nxt_state = rsw_pkg::ST_HOLD;
        end
      end
      rsw_pkg::ST_HOLD: begin
        if (hold_ff == HOLD_W'(1)) begin
          nxt_state = rsw_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= rsw_pkg::ST_RUN;
      hold_ff <= '0;
      sys_rst_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      sys_rst_n_ff <= (nxt_state == rsw_pkg::ST_RUN);
      if (entry) begin
        hold_ff <= HOLD_W'(RESET_HOLD);
      end else if (hold_ff != '0) begin
        hold_ff <= hold_ff - 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Reset cause flags
  // ----------------------------------------
  // Only the power-on reset loads POR_FLAGS; system resets rewrite them, a debug reset clears them.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= rsw_pkg::POR_FLAGS;
    end else if (entry) begin
      status_ff <= dbg_src ? 8'h00 : cause;
    end
  end

  // ----------------------------------------
  // Refresh key
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_ff <= 1'b0;
    end else if (entry) begin
      arm_ff <= 1'b0;
    end else if (key_write) begin
      arm_ff <= (reg_wdata == rsw_pkg::KEY_ARM);
    end
  end

  // ----------------------------------------
  // Write-once option registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      soo_ff <= rsw_pkg::SOO_RST;
      soo_once_ff <= 1'b0;
    end else if (entry) begin
      soo_ff <= rsw_pkg::SOO_RST;
      soo_once_ff <= 1'b0;
    end else if (running && reg_wr && (reg_addr == rsw_pkg::SOO_IDX) && !soo_once_ff) begin
      soo_ff <= reg_wdata & rsw_pkg::SOO_MASK;
      soo_once_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdo_ff <= rsw_pkg::WDO_RST;
      wdo_once_ff <= 1'b0;
    end else if (entry) begin
      wdo_ff <= rsw_pkg::WDO_RST;
      wdo_once_ff <= 1'b0;
    end else if (running && reg_wr && (reg_addr == rsw_pkg::WDO_IDX) && !wdo_once_ff) begin
      wdo_ff <= reg_wdata & rsw_pkg::WDO_MASK;
      wdo_once_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        rsw_pkg::RCS_IDX: rdata_ff <= status_ff;
        rsw_pkg::DFR_IDX: rdata_ff <= rsw_pkg::READ_ZERO;
        rsw_pkg::SOO_IDX: rdata_ff <= soo_ff;
        rsw_pkg::WDO_IDX: rdata_ff <= wdo_ff;
      endcase
    end
  end

  assign reg_rdata = rdata_ff;
  assign sys_rst_n = sys_rst_n_ff;
  assign sleep_allow = soo_ff[rsw_pkg::SOO_SLEEP];
  assign uart2_pin_sel = soo_ff[rsw_pkg::SOO_UART2];
  assign i2c_pin_sel = soo_ff[rsw_pkg::SOO_I2C];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_chk_ff <= 1'b1;
    end else begin
      por_chk_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_arm;
    key_write && (reg_wdata == rsw_pkg::KEY_ARM);
  endsequence

  sequence s_fire;
    key_write && (reg_wdata == rsw_pkg::KEY_FIRE) && wd_on && !wd.early && !wd.expire
      && !pin_src && !opc_src && !access_bad && !clock_lost && !lv_src && !dbg_src;
  endsequence

  a_por_flags: assert property (por_chk_ff |-> status_ff == rsw_pkg::POR_FLAGS)
    else $error("power-on flags wrong");

  a_refresh_keeps: assert property (s_arm ##[1:4] s_fire |=>
    $stable(status_ff) && sys_rst_n_ff && arm_ff == 1'b0)
    else $error("refresh disturbed status or reset");

  a_bad_key_rst: assert property (bad_key && !dbg_src |=>
    status_ff[rsw_pkg::B_WDOG] && !sys_rst_n_ff)
    else $error("bad key did not reset");

  a_debug_clear: assert property (running && dbg_src |=>
    (status_ff == 8'h00) && !sys_rst_n_ff [*2])
    else $error("debug reset left flags set");

  a_flags_stable: assert property (!entry |=> $stable(status_ff))
    else $error("status changed without reset");

  a_dbg_reads_zero: assert property (reg_rd && reg_addr == rsw_pkg::DFR_IDX |=>
    reg_rdata == 8'h00)
    else $error("debug register read nonzero");

  a_opts_once: assert property (soo_once_ff && !entry |=> $stable(soo_ff))
    else $error("options changed after first write");

  a_sleep_illegal: assert property (running && sleep_exec && !sleep_allow && !dbg_src |=>
    status_ff[rsw_pkg::B_OPC] && !sys_rst_n_ff)
    else $error("sleep not trapped");

  a_cause_match: assert property (entry && !dbg_src |=>
    status_ff == $past(cause))
    else $error("flags differ from active sources");

  a_window_early: assert property (win_bad && !dbg_src |=>
    status_ff[rsw_pkg::B_WDOG] ##1 !sys_rst_n_ff)
    else $error("early key write not trapped");

  a_lv_gate: assert property (entry && !dbg_src && !low_voltage_reset_en |=>
    !status_ff[rsw_pkg::B_LV])
    else $error("low-voltage flag without enable");
endmodule

// ---- verilog/rsw_pkg.sv ----
package rsw_pkg;
  // ----------------------------------------
  // Register indices on the register port
  // ----------------------------------------
  localparam logic [1:0] RCS_IDX = 2'h0;
  localparam logic [1:0] DFR_IDX = 2'h1;
  localparam logic [1:0] SOO_IDX = 2'h2;
  localparam logic [1:0] WDO_IDX = 2'h3;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int B_POR = 7;
  localparam int B_PIN = 6;
  localparam int B_WDOG = 5;
  localparam int B_OPC = 4;
  localparam int B_ACC = 3;
  localparam int B_CLK = 2;
  localparam int B_LV = 1;
  localparam int DFR_BIT = 0;
  localparam int SOO_TO_HI = 7;
  localparam int SOO_TO_LO = 6;
  localparam int SOO_SLEEP = 5;
  localparam int SOO_UART2 = 4;
  localparam int SOO_I2C = 3;
  localparam int WDO_CLK = 7;
  localparam int WDO_WIN = 6;

  // ----------------------------------------
  // Reset values, masks, keys
  // ----------------------------------------
  localparam logic [7:0] POR_FLAGS = 8'h82;
  localparam logic [7:0] SOO_RST = 8'hc0;
  localparam logic [7:0] WDO_RST = 8'h00;
  localparam logic [7:0] SOO_MASK = 8'hf8;
  localparam logic [7:0] WDO_MASK = 8'hc0;
  localparam logic [7:0] KEY_ARM = 8'h55;
  localparam logic [7:0] KEY_FIRE = 8'haa;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------
  // Watchdog timing
  // ----------------------------------------
  localparam int LPO_PERIOD_US = 1000;
  localparam int LPO_T1_MS = 32;
  localparam int LPO_T2_MS = 256;
  localparam int LPO_T3_MS = 1024;
  localparam int LPO_CYC1 = LPO_T1_MS * 1000 / LPO_PERIOD_US;
  localparam int LPO_CYC2 = LPO_T2_MS * 1000 / LPO_PERIOD_US;
  localparam int LPO_CYC3 = LPO_T3_MS * 1000 / LPO_PERIOD_US;
  localparam int BUS_EXP1 = 13;
  localparam int BUS_EXP2 = 16;
  localparam int BUS_EXP3 = 18;
  localparam int CNT_W = 19;

  typedef enum logic {
    ST_RUN = 1'b0,
    ST_HOLD = 1'b1
  } rsw_state_e;
endpackage

// ---- verilog/rsw_wdog_cnt.sv ----
`timescale 1ns/1ns
module rsw_wdog_cnt #(
  parameter int unsigned BUS_PER1 = 8192,
  parameter int unsigned BUS_PER2 = 65536,
  parameter int unsigned BUS_PER3 = 262144
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control side
  rsw_wdog_if.cnt wd
);
  logic [rsw_pkg::CNT_W-1:0] cnt_ff;
  logic [rsw_pkg::CNT_W-1:0] limit;
  logic [rsw_pkg::CNT_W-1:0] open_at;
  logic expire_ff;
  logic step;
  logic at_end;

  // ----------------------------------------
  // Period select
  // ----------------------------------------
  always_comb begin
    case ({wd.clk_sel, wd.timeout_sel})
      3'b001: limit = rsw_pkg::CNT_W'(rsw_pkg::LPO_CYC1);
      3'b010: limit = rsw_pkg::CNT_W'(rsw_pkg::LPO_CYC2);
      3'b011: limit = rsw_pkg::CNT_W'(rsw_pkg::LPO_CYC3);
      3'b101: limit = rsw_pkg::CNT_W'(BUS_PER1);
      3'b110: limit = rsw_pkg::CNT_W'(BUS_PER2);
      3'b111: limit = rsw_pkg::CNT_W'(BUS_PER3);
      default: limit = '0;
    endcase
  end

  // Last quarter of the period is the refresh window
  assign open_at = limit - (limit >> 2);
  assign step = (wd.timeout_sel != 2'h0) && (wd.clk_sel || wd.tick);
  assign at_end = (cnt_ff == limit - 1'b1);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (wd.clear) begin
      cnt_ff <= '0;
    end else if (step) begin
      cnt_ff <= at_end ? '0 : cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      expire_ff <= 1'b0;
    end else begin
      expire_ff <= !wd.clear && step && at_end;
    end
  end

  assign wd.expire = expire_ff;
  assign wd.early = wd.window_en && (wd.timeout_sel != 2'h0) && (cnt_ff < open_at);

  a_cnt_below_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wd.timeout_sel != 2'h0) |-> (cnt_ff < limit))
    else $error("watchdog count passed its period");
endmodule

// ---- verilog/rsw_wdog_if.sv ----
`timescale 1ns/1ns
interface rsw_wdog_if;
  logic [1:0] timeout_sel;
  logic clk_sel;
  logic window_en;
  logic tick;
  logic clear;
  logic early;
  logic expire;
  modport ctrl (output timeout_sel, output clk_sel, output window_en, output tick,
    output clear, input early, input expire);
  modport cnt (input timeout_sel, input clk_sel, input window_en, input tick,
    input clear, output early, output expire);
endinterface
